// File: hw/cps_defines.svh
/*
  Constants for the phase sequencer: timing, memory geometry, address map,
  instruction fields and register offsets. Assumes a 100 ns system clock.
*/
`ifndef CPS_DEFINES_SVH
`define CPS_DEFINES_SVH
// ==========================================================
// timing
`define CPS_CLK_NS 100
`define CPS_PHASE_NS 2000
`define CPS_ISZ_NS 2500
`define CPS_PHASE_CYC ((`CPS_PHASE_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_ISZ_CYC ((`CPS_ISZ_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_READ_CYC 1
`define CPS_WRITE_CYC (`CPS_PHASE_CYC / 2)
// ==========================================================
// memory and address map
`define CPS_BASE_WORDS 4096
`define CPS_EXP_WORDS 8192
`define CPS_PROT_WORDS 64
`define CPS_ACCA_ADDR 0
`define CPS_ACCB_ADDR 1
`define CPS_VEC_PWR 4
`define CPS_VEC_PAR 5
`define CPS_VEC_DMA 6
`define CPS_VEC_FIRST 8
`define CPS_VEC_LAST 63
// ==========================================================
// instruction fields
`define CPS_BIT_IND 15
`define CPS_BIT_PAGE 10
`define CPS_OP_JUMP 4'h5
`define CPS_OP_ISZ 4'h7
// ==========================================================
// register offsets and control bits
`define CPS_REG_CTRL 8'h00
`define CPS_REG_STAT 8'h04
`define CPS_REG_PC 8'h08
`define CPS_REG_MAR 8'h0C
`define CPS_REG_TREG 8'h10
`define CPS_REG_ACCA 8'h14
`define CPS_REG_ACCB 8'h18
`define CPS_REG_LDADDR 8'h1C
`define CPS_REG_LDDATA 8'h20
`define CPS_CTRL_RUN 0
`define CPS_CTRL_INTEN 1
`define CPS_CTRL_LDREN 2
`define CPS_CTRL_EXPAND 3
`endif

// File: hw/cps_pkg.sv
/*
  Types for the phase sequencer. Needs nothing from its surroundings.
*/
package cps_pkg;
  // ==========================================================
  // machine phases
  typedef enum logic [2:0] {PH_FETCH, PH_INDIRECT, PH_EXECUTE, PH_INTERRUPT, PH_SUSPEND} cps_phase_e;
endpackage

// File: hw/cps_phase_sequencer.sv
/*
  Machine-phase sequencer with core memory, address generation, interrupt
  entry, DMA suspend and loader protection, behind an AHB-Lite slave.
  Assumes one 10 MHz clock, a single AHB master, and DMA address/data pins
  held stable while the DMA request is high.
*/
// Behaviour
// - phase timing from internal divider; one memory cycle every 2.0 us running
// - fetch, indirect, execute, interrupt phases; first three hold a memory cycle
// - each phase 2.0 us; increment-skip-zero execute lasts 2.5 us
// - service request accepted at phase end into interrupt unless inhibited
// - memory cycle reads cell into transfer register then restores it
// - fetch end: indirect MRI to indirect, direct non-jump to execute, others complete
// - jump completes at fetch or final indirect end, then fetch
// - indirect word gives 15-bit address and new indirect bit, unlimited levels
// - direct indirect word selects execute, or fetch for jump
// - execute reads operand, retained instruction acts at end, then fetch
// - interrupt phase decrements program counter
// - interrupt end loads vector into address, fetch, blocks next interrupt
// - DMA request suspends after current cycle for one cycle then resumes
// - memory 4096 or 8192 words of 16 data bits plus parity
// - 10-bit in-page address field, pages of 1024 words
// - instruction bit 10 picks base page or current page
// - bit 15 selects direct or indirect addressing
// - addresses 0 and 1 reach the two accumulators, not core
// - fixed interrupt vectors 4, 5, 6 then 010-077 by priority
// - loader protect blocks writes to top 64 words of installed memory
// - completed non-jump instruction advances program counter by one, or two on skip
`timescale 1ns/1ns
`include "cps_defines.svh"
module cps_phase_sequencer #(
  parameter int NIRQ = 59,
  parameter int MEM_WORDS = `CPS_EXP_WORDS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt requests, index 0 highest priority
  input wire logic [NIRQ-1:0] irqReq,
  // DMA channel
  input wire logic dmaReq,
  input wire logic dmaWrite,
  input wire logic [14:0] dmaAddr,
  input wire logic [15:0] dmaData,
  output logic dmaAck,
  output logic [15:0] dmaRdData
);
  localparam int PH_CYC = `CPS_PHASE_CYC;
  localparam int ISZ_CYC = `CPS_ISZ_CYC;

  // ==========================================================
  // state
  typedef struct packed {
    cps_pkg::cps_phase_e phase;
    cps_pkg::cps_phase_e resumePhase;
    logic [4:0] cnt;
    logic [14:0] pc;
    logic [14:0] mar;
    logic [15:0] treg;
    logic [15:0] ir;
    logic [15:0] accA;
    logic [15:0] accB;
    logic [5:0] intVec;
    logic intBlock;
    logic run;
    logic intEn;
    logic ldrEn;
    logic expand;
    logic [14:0] loadAddr;
    logic [NIRQ-1:0] irqS1;
    logic [NIRQ-1:0] irqS2;
    logic dmaS1;
    logic dmaS2;
    // {write, address, data} from the pins, two stages like the request
    logic [31:0] dmaQ1;
    logic [31:0] dmaQ2;
    logic dmaWr;
    logic [14:0] dmaA;
    logic [15:0] dmaD;
    logic dmaAck;
    logic [15:0] dmaRdData;
    logic busValid;
    logic busWr;
    logic [7:0] busAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic memWe;
    logic [12:0] memWa;
    logic [16:0] memWd;
  } cps_state_s;

  cps_state_s r;
  cps_state_s next_r;
  logic [16:0] mem [0:MEM_WORDS-1];

  // ==========================================================
  // functions
  // address folds into installed size
  function automatic logic [12:0] memIdx(input logic [14:0] a, input logic exp);
    memIdx = exp ? a[12:0] : {1'b0, a[11:0]};
  endfunction

  // top 64 words follow memory size
  function automatic logic isProtected(input logic [12:0] idx, input logic exp);
    logic [12:0] base;
    base = exp ? 13'(`CPS_EXP_WORDS - `CPS_PROT_WORDS) : 13'(`CPS_BASE_WORDS - `CPS_PROT_WORDS);
    isProtected = idx >= base;
  endfunction

  function automatic logic [14:0] effAddr(input logic [15:0] ins, input logic [14:0] loc);
    effAddr = ins[`CPS_BIT_PAGE] ? {loc[14:10], ins[9:0]} : {5'h00, ins[9:0]};
  endfunction

  function automatic logic [6:0] irqVector(input logic [NIRQ-1:0] req);
    irqVector = 7'h00;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        if (i < 3) irqVector = {1'b1, 6'(`CPS_VEC_PWR + i)};
        else irqVector = {1'b1, 6'(`CPS_VEC_FIRST + i - 3)};
      end
    end
  endfunction

  // accumulators overlay the two lowest addresses
  function automatic logic [15:0] readWord(input cps_state_s s, input logic [14:0] a, input logic [16:0] m);
    if (a == 15'(`CPS_ACCA_ADDR)) readWord = s.accA;
    else if (a == 15'(`CPS_ACCB_ADDR)) readWord = s.accB;
    else readWord = m[15:0];
  endfunction

  // ==========================================================
  // next state
  logic [16:0] memRdCpu;
  logic [16:0] memRdDma;
  logic [16:0] memRdLoad;
  assign memRdCpu = mem[memIdx(r.mar, r.expand)];
  assign memRdDma = mem[memIdx(r.dmaA, r.expand)];
  assign memRdLoad = mem[memIdx(r.loadAddr, r.expand)];

  always_comb begin
    logic memPhase;
    logic isMri;
    logic isJump;
    logic isIsz;
    logic lastCnt;
    logic complete;
    logic skip;
    logic [15:0] wrWord;
    logic [14:0] wrAddr;
    logic [6:0] vec;
    cps_pkg::cps_phase_e nph;
    memPhase = 1'b0;
    isMri = 1'b0;
    isJump = 1'b0;
    isIsz = 1'b0;
    lastCnt = 1'b0;
    complete = 1'b0;
    skip = 1'b0;
    wrWord = 16'h0000;
    wrAddr = 15'h0000;
    vec = 7'h00;
    nph = r.phase;
    next_r = r;
    next_r.irqS1 = irqReq;
    next_r.irqS2 = r.irqS1;
    next_r.dmaS1 = dmaReq;
    next_r.dmaS2 = r.dmaS1;
    next_r.dmaQ1 = {dmaWrite, dmaAddr, dmaData};
    next_r.dmaQ2 = r.dmaQ1;
    next_r.dmaAck = 1'b0;
    next_r.memWe = 1'b0;
    next_r.hreadyout = 1'b1;
    isIsz = r.ir[14:11] == `CPS_OP_ISZ;
    memPhase = r.phase == cps_pkg::PH_FETCH || r.phase == cps_pkg::PH_INDIRECT || r.phase == cps_pkg::PH_EXECUTE;
    lastCnt = (r.phase == cps_pkg::PH_EXECUTE && isIsz) ? r.cnt == 5'(ISZ_CYC - 1) : r.cnt == 5'(PH_CYC - 1);
    if (r.run) begin
      // phase counter paces the memory cycles
      next_r.cnt = lastCnt ? 5'h00 : r.cnt + 5'h01;
      if (r.cnt == 5'(`CPS_READ_CYC)) begin
        if (memPhase) next_r.treg = readWord(r, r.mar, memRdCpu);
        if (r.phase == cps_pkg::PH_SUSPEND) next_r.dmaRdData = readWord(r, r.dmaA, memRdDma);
      end
      if (r.cnt == 5'(`CPS_WRITE_CYC) && (memPhase || r.phase == cps_pkg::PH_SUSPEND)) begin
        wrAddr = memPhase ? r.mar : r.dmaA;
        wrWord = memPhase ? r.treg : (r.dmaWr ? r.dmaD : r.dmaRdData);
        if (r.phase == cps_pkg::PH_EXECUTE && isIsz) begin
          wrWord = r.treg + 16'h0001;
          next_r.treg = wrWord;
        end
        // accumulator writes stay out of core
        if (wrAddr == 15'(`CPS_ACCA_ADDR)) next_r.accA = wrWord;
        else if (wrAddr == 15'(`CPS_ACCB_ADDR)) next_r.accB = wrWord;
        else if (r.ldrEn || !isProtected(memIdx(wrAddr, r.expand), r.expand)) begin
          next_r.memWe = 1'b1;
          next_r.memWa = memIdx(wrAddr, r.expand);
          next_r.memWd = {^wrWord, wrWord};
        end
      end
      if (lastCnt) begin
        isMri = r.treg[14:12] != 3'h0;
        isJump = r.treg[14:11] == `CPS_OP_JUMP;
        case (r.phase)
          cps_pkg::PH_FETCH: begin
            next_r.ir = r.treg;
            if (isMri && r.treg[`CPS_BIT_IND]) begin
              nph = cps_pkg::PH_INDIRECT;
              next_r.mar = effAddr(r.treg, r.mar);
            end else if (isMri && isJump) begin
              complete = 1'b1;
              next_r.pc = effAddr(r.treg, r.mar);
            end else if (isMri) begin
              nph = cps_pkg::PH_EXECUTE;
              next_r.mar = effAddr(r.treg, r.mar);
            end else begin
              complete = 1'b1;
              next_r.pc = r.pc + 15'h0001;
            end
          end
          cps_pkg::PH_INDIRECT: begin
            next_r.mar = r.treg[14:0];
            if (r.treg[`CPS_BIT_IND]) begin
              nph = cps_pkg::PH_INDIRECT;
            end else if (r.ir[14:11] == `CPS_OP_JUMP) begin
              complete = 1'b1;
              next_r.pc = r.treg[14:0];
            end else begin
              nph = cps_pkg::PH_EXECUTE;
            end
          end
          cps_pkg::PH_EXECUTE: begin
            complete = 1'b1;
            skip = isIsz && r.treg == 16'h0000;
            next_r.pc = r.pc + (skip ? 15'h0002 : 15'h0001);
          end
          cps_pkg::PH_INTERRUPT: begin
            next_r.pc = r.pc - 15'h0001;
            next_r.mar = {9'h000, r.intVec};
            next_r.intBlock = 1'b1;
            nph = cps_pkg::PH_FETCH;
          end
          cps_pkg::PH_SUSPEND: begin
            next_r.dmaAck = 1'b1;
            nph = r.resumePhase;
          end
          default: nph = cps_pkg::PH_FETCH;
        endcase
        if (complete) begin
          nph = cps_pkg::PH_FETCH;
          next_r.mar = next_r.pc;
          next_r.intBlock = 1'b0;
        end
        vec = irqVector(r.irqS2);
        if (r.dmaS2 && r.phase != cps_pkg::PH_SUSPEND) begin
          next_r.resumePhase = nph;
          next_r.dmaA = r.dmaQ2[30:16];
          next_r.dmaD = r.dmaQ2[15:0];
          next_r.dmaWr = r.dmaQ2[31];
          nph = cps_pkg::PH_SUSPEND;
        end else if (vec[6] && r.intEn && !next_r.intBlock && r.phase != cps_pkg::PH_INTERRUPT) begin
          next_r.intVec = vec[5:0];
          nph = cps_pkg::PH_INTERRUPT;
        end
        next_r.phase = nph;
      end
    end
    // bus data phase
    if (r.busValid && r.busWr) begin
      case (r.busAddr)
        `CPS_REG_CTRL: begin
          next_r.run = hwdata[`CPS_CTRL_RUN];
          next_r.intEn = hwdata[`CPS_CTRL_INTEN];
          next_r.ldrEn = hwdata[`CPS_CTRL_LDREN];
          next_r.expand = hwdata[`CPS_CTRL_EXPAND];
        end
        `CPS_REG_PC: begin
          next_r.pc = hwdata[14:0];
          next_r.mar = hwdata[14:0];
          next_r.phase = cps_pkg::PH_FETCH;
          next_r.cnt = 5'h00;
        end
        `CPS_REG_ACCA: next_r.accA = hwdata[15:0];
        `CPS_REG_ACCB: next_r.accB = hwdata[15:0];
        `CPS_REG_LDADDR: next_r.loadAddr = hwdata[14:0];
        `CPS_REG_LDDATA: begin
          // panel-style load only while halted, so it never meets a core cycle
          if (!r.run) begin
            if (r.loadAddr == 15'(`CPS_ACCA_ADDR)) next_r.accA = hwdata[15:0];
            else if (r.loadAddr == 15'(`CPS_ACCB_ADDR)) next_r.accB = hwdata[15:0];
            else if (r.ldrEn || !isProtected(memIdx(r.loadAddr, r.expand), r.expand)) begin
              next_r.memWe = 1'b1;
              next_r.memWa = memIdx(r.loadAddr, r.expand);
              next_r.memWd = {^hwdata[15:0], hwdata[15:0]};
            end
            next_r.loadAddr = r.loadAddr + 15'h0001;
          end
        end
        default: next_r.run = r.run;
      endcase
    end
    // bus address phase
    next_r.busValid = hsel && htrans[1] && hready;
    next_r.busWr = hwrite;
    next_r.busAddr = haddr;
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr)
        `CPS_REG_CTRL: next_r.hrdata = {28'h0000000, r.expand, r.ldrEn, r.intEn, r.run};
        `CPS_REG_STAT: next_r.hrdata = {26'h0000000, r.dmaS2, r.intBlock, 1'b0, r.phase};
        `CPS_REG_PC: next_r.hrdata = {17'h00000, r.pc};
        `CPS_REG_MAR: next_r.hrdata = {17'h00000, r.mar};
        `CPS_REG_TREG: next_r.hrdata = {16'h0000, r.treg};
        `CPS_REG_ACCA: next_r.hrdata = {16'h0000, r.accA};
        `CPS_REG_ACCB: next_r.hrdata = {16'h0000, r.accB};
        `CPS_REG_LDADDR: next_r.hrdata = {17'h00000, r.loadAddr};
        `CPS_REG_LDDATA: next_r.hrdata = {16'h0000, readWord(r, r.loadAddr, memRdLoad)};
        default: next_r.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.phase <= cps_pkg::PH_FETCH;
      r.resumePhase <= cps_pkg::PH_FETCH;
    end else begin
      r <= next_r;
    end
  end

  // no reset on the core array: contents survive like core
  always_ff @(posedge sys_clk) begin
    if (r.memWe) mem[r.memWa] <= r.memWd;
  end

  assign hreadyout = r.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign dmaAck = r.dmaAck;
  assign dmaRdData = r.dmaRdData;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_fetch_len: assert property ($past(r.phase) == cps_pkg::PH_FETCH && r.phase != cps_pkg::PH_FETCH && $past(r.run)
    && !$past(r.busValid) |-> $past(r.cnt) == 5'(PH_CYC - 1)) else $error("fetch phase length wrong");
  a_isz_len: assert property (r.phase == cps_pkg::PH_EXECUTE && r.ir[14:11] == `CPS_OP_ISZ && r.cnt == 5'(PH_CYC - 1)
    && r.run && !r.busValid |=> r.phase == cps_pkg::PH_EXECUTE) else $error("isz execute ended early");
  a_int_nomem: assert property (r.phase == cps_pkg::PH_INTERRUPT && r.run |=> !r.memWe)
    else $error("memory write in interrupt phase");
  a_int_exit: assert property (r.phase == cps_pkg::PH_INTERRUPT && r.run && r.cnt == 5'(PH_CYC - 1) && !r.busValid
    |=> r.mar == {9'h000, $past(r.intVec)} && r.intBlock && r.pc == $past(r.pc) - 15'h0001)
    else $error("interrupt exit wrong");
  a_prot_wr: assert property (r.memWe && !r.ldrEn |-> !isProtected(r.memWa, r.expand))
    else $error("loader area written");
  a_acc_core: assert property (r.memWe |-> r.memWa > 13'h0001 || r.expand && r.memWa[12])
    else $error("accumulator address reached core");
  a_dma_cycle: assert property ($rose(r.phase == cps_pkg::PH_SUSPEND) && !r.busValid |->
    ##19 r.phase == cps_pkg::PH_SUSPEND ##1 r.phase != cps_pkg::PH_SUSPEND && r.dmaAck)
    else $error("suspend not one cycle");
  a_ind_stay: assert property (r.phase == cps_pkg::PH_INDIRECT && r.run && r.cnt == 5'(PH_CYC - 1) && r.treg[15]
    && !r.dmaS2 && !r.busValid |=> r.phase == cps_pkg::PH_INDIRECT && r.mar == $past(r.treg[14:0]))
    else $error("indirect chain broken");

  c_indirect: cover property (r.phase == cps_pkg::PH_INDIRECT ##1 r.phase == cps_pkg::PH_EXECUTE);
  c_interrupt: cover property (r.phase == cps_pkg::PH_INTERRUPT ##1 r.phase == cps_pkg::PH_FETCH);
  c_suspend: cover property (r.dmaAck);
  c_skip: cover property (r.phase == cps_pkg::PH_EXECUTE && r.ir[14:11] == `CPS_OP_ISZ ##1 r.phase == cps_pkg::PH_FETCH);
endmodule

// File: testbench/cps_far_model.sv
/*
  Far side of the sequencer: interrupt requesters and a DMA channel.
  Assumes the bench calls its tasks just after a rising sysClk edge.
*/
`timescale 1ns/1ns
module cps_far_model #(
  parameter int NIRQ = 59
) (
  // clock
  input wire logic sysClk,
  // interrupt requesters
  output logic [NIRQ-1:0] irqReq,
  // dma channel
  output logic dmaReq,
  output logic dmaWrite,
  output logic [14:0] dmaAddr,
  output logic [15:0] dmaData,
  input wire logic dmaAck,
  input wire logic [15:0] dmaRdData
);
  // ==========================================================
  // idle levels
  initial begin
    irqReq = '0;
    dmaReq = 1'b0;
    dmaWrite = 1'b0;
    dmaAddr = '1;
    dmaData = '1;
  end
  // ==========================================================
  // request tasks
  task automatic setIrq(input logic [NIRQ-1:0] lvl);
    @(posedge sysClk);
    irqReq <= lvl;
  endtask
  // request and qualifiers held until the acknowledge edge
  task automatic dmaXfer(input logic wr, input logic [14:0] a, input logic [15:0] d,
                         output logic [15:0] rd, output int tAck);
    int n;
    n = 0;
    @(posedge sysClk);
    dmaReq <= 1'b1;
    dmaWrite <= wr;
    dmaAddr <= a;
    dmaData <= d;
    do begin
      @(posedge sysClk);
      n++;
    end while (dmaAck !== 1'b1 && n < 200);
    rd = dmaRdData;
    tAck = int'($time / 100);
    // released lines show the inverse so stale values cannot pass
    dmaReq <= 1'b0;
    dmaWrite <= ~wr;
    dmaAddr <= ~a;
    dmaData <= ~d;
  endtask
endmodule

// File: testbench/testbench.sv
/*
  Self-checking bench: AHB-Lite register tasks drive load, protection,
  program, interrupt and DMA sequences. Assumes cps_far_model and the defines.
*/
`timescale 1ns/1ns
`include "cps_defines.svh"
module testbench;
  // ==========================================================
  // constants
  localparam int PH = `CPS_PHASE_CYC;
  localparam int IZ = `CPS_ISZ_CYC;
  localparam logic [31:0] RUN = 32'h1 << `CPS_CTRL_RUN;
  localparam logic [31:0] INTEN = 32'h1 << `CPS_CTRL_INTEN;
  localparam logic [31:0] LDREN = 32'h1 << `CPS_CTRL_LDREN;
  localparam logic [31:0] EXP8K = 32'h1 << `CPS_CTRL_EXPAND;
  localparam logic [7:0] RA [5] = '{`CPS_REG_CTRL, `CPS_REG_STAT, `CPS_REG_PC, `CPS_REG_MAR, 8'h40};
  localparam logic [15:0] PA [13] = '{16'h0004, 16'h0005, 16'h0006, 16'h0008, 16'h003F, 16'h0020,
    16'h0030, 16'h0031, 16'h0500, 16'h0405, 16'h0406, 16'h0407, 16'h0700};
  // jump, increment-skip and a two-level indirect jump
  localparam logic [15:0] PD [13] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
    16'h8031, 16'h0600, 16'h2C05, 16'h3820, 16'h0000, 16'hA830, 16'h0BAD};
  localparam int IDX [5] = '{0, 1, 2, 3, 58};
  localparam logic [31:0] VEC [5] = '{32'h4, 32'h5, 32'h6, 32'h8, 32'h3F};
  // ==========================================================
  // signals
  logic sysClk, rstN, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [58:0] irqReq;
  logic dmaReq, dmaWrite, dmaAck;
  logic [14:0] dmaAddr;
  logic [15:0] dmaData, dmaRdData;
  int errors = 0;
  int tests_run = 0;
  cps_phase_sequencer #(.NIRQ(59), .MEM_WORDS(`CPS_EXP_WORDS)) i_dut (
    .sys_clk(sysClk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irqReq(irqReq), .dmaReq(dmaReq), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr),
    .dmaData(dmaData), .dmaAck(dmaAck), .dmaRdData(dmaRdData));
  cps_far_model #(.NIRQ(59)) i_far (
    .sysClk(sysClk), .irqReq(irqReq), .dmaReq(dmaReq), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr),
    .dmaData(dmaData), .dmaAck(dmaAck), .dmaRdData(dmaRdData));
  // ==========================================================
  // clock and watchdog
  initial begin
    sysClk = 1'b0;
    forever #50 sysClk = ~sysClk;
  end
  initial begin
    #2000000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  // ==========================================================
  // tasks
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkIn(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi) begin
      errors++;
      $display("[ERR] %0t value %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    do begin
      @(posedge sysClk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge sysClk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic memWr(input logic [15:0] a, input logic [15:0] d);
    wrReg(`CPS_REG_LDADDR, {16'h0, a});
    wrReg(`CPS_REG_LDDATA, {16'h0, d});
  endtask
  task automatic memRd(input logic [15:0] a, output logic [31:0] d);
    wrReg(`CPS_REG_LDADDR, {16'h0, a});
    rdReg(`CPS_REG_LDDATA, d);
  endtask
  // poll until masked value matches; t is the cycle of detection
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input int maxRd,
                      output logic [31:0] hit, output int t);
    logic [31:0] d;
    hit = 32'h0;
    for (int i = 0; i < maxRd && hit == 32'h0; i++) begin
      rdReg(a, d);
      hit = ((d & m) === v) ? 32'h1 : 32'h0;
    end
    t = int'($time / 100);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d, e, hit;
    logic [15:0] rd;
    int t0, t1, t2, tA;
    rstN = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (2) @(posedge sysClk);
    rstN <= 1'b1;
    @(posedge sysClk);
    for (int i = 0; i < 5; i++) begin
      rdReg(RA[i], d);
      chk(d, 32'h0);
    end
    wrReg(`CPS_REG_ACCA, 32'h11);
    wrReg(`CPS_REG_ACCB, 32'h22);
    memRd(16'h0000, d);
    chk(d, 32'h11);
    memRd(16'h0001, d);
    chk(d, 32'h22);
    // protected top follows the installed size
    wrReg(`CPS_REG_CTRL, LDREN | EXP8K);
    memWr(16'h1FFF, 16'hAAAA);
    memWr(16'h0FFF, 16'hAAAA);
    wrReg(`CPS_REG_CTRL, EXP8K);
    memWr(16'h1FFF, 16'h5555);
    memWr(16'h0FFF, 16'h5555);
    memRd(16'h1FFF, d);
    chk(d, 32'hAAAA);
    memRd(16'h0FFF, d);
    chk(d, 32'h5555);
    wrReg(`CPS_REG_CTRL, LDREN);
    memWr(16'h0FFF, 16'hAAAA);
    wrReg(`CPS_REG_CTRL, 32'h0);
    memWr(16'h0FFF, 16'h5555);
    memWr(16'h0FBF, 16'h5555);
    memRd(16'h0FFF, d);
    chk(d, 32'hAAAA);
    memRd(16'h0FBF, d);
    chk(d, 32'h5555);
    for (int i = 0; i < 13; i++)
      memWr(PA[i], PD[i]);
    wrReg(`CPS_REG_LDADDR, 32'h600);
    repeat (256) wrReg(`CPS_REG_LDDATA, 32'h0);
    // program run, timed by program counter changes
    wrReg(`CPS_REG_PC, 32'h500);
    wrReg(`CPS_REG_CTRL, RUN);
    t0 = int'($time / 100);
    poll(`CPS_REG_PC, 32'hFFFF, 32'h405, 40, hit, t1);
    chkIn(t1 - t0, PH, PH + 6);
    poll(`CPS_REG_PC, 32'hFFFF, 32'h407, 40, hit, t2);
    chkIn(t2 - t1, PH + IZ - 2, PH + IZ + 2);
    poll(`CPS_REG_PC, 32'hFFFF, 32'h600, 60, hit, t1);
    chkIn(t1 - t2, 3 * PH - 2, 3 * PH + 2);
    poll(`CPS_REG_PC, 32'hFFFF, 32'h602, 40, hit, t2);
    chkIn(t2 - t1, 2 * PH - 2, 2 * PH + 2);
    // interrupts: inhibited, then vectors 4, 5, 6, 010 and 077, all but 077 with a lower request pending
    i_far.setIrq(59'h8);
    poll(`CPS_REG_STAT, 32'h7, 32'h3, 30, hit, t0);
    chk(hit, 32'h0);
    i_far.setIrq(59'h0);
    wrReg(`CPS_REG_CTRL, RUN | INTEN);
    for (int k = 0; k < 5; k++) begin
      i_far.setIrq((59'h1 << IDX[k]) | (59'h1 << 58));
      poll(`CPS_REG_STAT, 32'h7, 32'h3, 30, hit, t0);
      chk(hit, 32'h1);
      poll(`CPS_REG_STAT, 32'h17, 32'h10, 15, hit, t1);
      chkIn(t1 - t0, PH - 2, PH + 2);
      rdReg(`CPS_REG_MAR, d);
      chk(d, VEC[k]);
      i_far.setIrq(59'h0);
      repeat (2 * PH) @(posedge sysClk);
      rdReg(`CPS_REG_STAT, d);
      chk(d & 32'h10, 32'h0);
    end
    // dma write returns old contents, then read back
    fork
      i_far.dmaXfer(1'b1, 15'h0700, 16'h1234, rd, tA);
      poll(`CPS_REG_STAT, 32'h7, 32'h4, 40, hit, t0);
    join
    chk(hit, 32'h1);
    chkIn(tA - t0, PH - 4, PH + 1);
    chk({16'h0, rd}, 32'h0BAD);
    i_far.dmaXfer(1'b0, 15'h0700, 16'h0000, rd, tA);
    chk({16'h0, rd}, 32'h1234);
    rdReg(`CPS_REG_PC, d);
    repeat (2 * PH) @(posedge sysClk);
    rdReg(`CPS_REG_PC, e);
    chkIn(int'(e[15:0] - d[15:0]), 1, 3);
    wrReg(`CPS_REG_CTRL, 32'h0);
    repeat (2 * PH) @(posedge sysClk);
    memRd(16'h0020, d);
    chk(d, 32'h0);
    memRd(16'h0700, d);
    chk(d, 32'h1234);
    results();
  end
endmodule
